// ==== verilog/pscr_stage.sv ====
// Register slice, clocking and event logic of a three-module PWM power stage
`timescale 1ns/1ps
`include "pscr_regs.svh"

// Behaviour
// - Each module has own request logic
// - Sources: input event, sync error (reload feeds only the end request)
// - Input event on edge or level onset
// - Clock select: 0 I/O, 1 PLL
// - Prescaler codes divide by 1/4/32/256
// - Fault vector 5 at 0x0004, end 6 at 0x0005
// - End request: enabled and module 0 cycle end (reset-B match, zero on the down ramp when centred)
// - Fault request: enabled and input fault event
// - Identical per-module registers, own copies
// - Six pin enables select waveform or port
// - Two-bit ADC trigger field per module
// - One-ramp trigger on chosen edge
// - Centred: reset-A match down/up, else none
// - Four 12-bit compares checked against counter
// - Compare writes go through temporary high byte
// - One temporary byte shared by all compares
// - Lock buffers compares and pin enables
// - Buffered values move after lock clears
// - Transfer happens at end of cycle, or at once while stopped
// - Flags set regardless of enable, write-one clears
module pscr_stage #(
	parameter int NMOD = 3
) (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  pll_clk_en,
	input  wire logic [NMOD-1:0]       fault_in,
	input  wire logic [NMOD-1:0]       fault_level_mode,
	input  wire logic [NMOD-1:0]       fault_active_high,
	input  wire logic [NMOD-1:0]       sync_error,
	input  wire logic [2*NMOD-1:0]     port_out,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic      [2*NMOD-1:0]     pin_out,
	output logic      [NMOD-1:0]       waveform_out_a,
	output logic      [NMOD-1:0]       waveform_out_b,
	output logic      [NMOD-1:0]       adc_trigger,
	output logic      [NMOD-1:0]       module_irq,
	output logic                       fault_vector_req,
	output logic                       end_of_cycle_vector_req
);
	import pscr_pkg::*;

	// ============================================================
	// Bus decode
	logic       wr_en;
	logic       rd_hit;
	logic [7:0] wbyte;
	logic       in_mod;
	logic [1:0] mod_sel;
	logic [5:0] mod_off;
	assign wr_en   = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign wbyte   = pwdata[7:0];
	assign in_mod  = (paddr >= `PSCR_OFF_MOD_BASE)
		&& (paddr < `PSCR_OFF_MOD_BASE + 12'(NMOD) * `PSCR_MOD_STRIDE);
	assign mod_sel = 2'((paddr - `PSCR_OFF_MOD_BASE) >> 6);
	assign mod_off = paddr[5:0];

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	function automatic logic mhit(input logic [5:0] a, input logic [11:0] off);
		return a == off[5:0];
	endfunction

	// ============================================================
	// Shared control registers
	logic [7:0] poe_buf_q;
	logic [7:0] poe_act_q;
	logic [7:0] sync_q;
	logic [7:0] cnf_q;
	logic [7:0] ctl_q;
	logic [7:0] imsk_q;
	logic [7:0] iflg_q;
	logic [7:0] temp_q;
	logic       lock;
	logic       centred;
	logic       run;
	assign lock    = cnf_q[`PSCR_CNF_LOCK];
	assign centred = cnf_q[`PSCR_CNF_MODE];
	assign run     = ctl_q[`PSCR_CTL_RUN];

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sync_q <= `PSCR_RST_BYTE;
			cnf_q  <= `PSCR_RST_BYTE;
			ctl_q  <= `PSCR_RST_BYTE;
			imsk_q <= `PSCR_RST_BYTE;
		end else if (wr_en) begin
			if (hit(paddr, `PSCR_OFF_SYNC))
				sync_q <= wbyte & `PSCR_SYNC_MASK;
			if (hit(paddr, `PSCR_OFF_CNF))
				cnf_q <= wbyte & `PSCR_CNF_MASK;
			if (hit(paddr, `PSCR_OFF_CTL))
				ctl_q <= wbyte & `PSCR_CTL_MASK;
			if (hit(paddr, `PSCR_OFF_IMSK))
				imsk_q <= wbyte & 8'h0f;
		end
	end

	// One temporary high byte serves every compare pair of every module
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			temp_q <= `PSCR_RST_BYTE;
		end else if (wr_en && in_mod && mod_off[2]) begin
			temp_q <= wbyte & `PSCR_HI_MASK;
		end
	end

	// ============================================================
	// Module clock enable: source select then prescaler
	logic [8:0] div_cnt_q;
	logic [8:0] div_n;
	logic       src_tick;
	logic       mod_tick;
	assign src_tick = ctl_q[`PSCR_CTL_CLKSEL] ? pll_clk_en : 1'b1;
	always_comb begin
		case (ctl_q[`PSCR_CTL_PRE_HI:`PSCR_CTL_PRE_LO])
			2'b00:   div_n = `PSCR_DIV_1;
			2'b01:   div_n = `PSCR_DIV_4;
			2'b10:   div_n = `PSCR_DIV_32;
			default: div_n = `PSCR_DIV_256;
		endcase
	end
	// Stopped stages see no ticks, so no compare can match at rest;
	// at-or-above lets a smaller prescaler take effect without a long wrap
	assign mod_tick = run && src_tick && (div_cnt_q >= div_n - 9'h001);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			div_cnt_q <= 9'h000;
		end else if (!run) begin
			div_cnt_q <= 9'h000;
		end else if (src_tick) begin
			div_cnt_q <= mod_tick ? 9'h000 : div_cnt_q + 9'h001;
		end
	end

	// ============================================================
	// Fault input synchronisers
	logic [NMOD-1:0] fin_m_q;
	logic [NMOD-1:0] fin_s_q;
	logic [NMOD-1:0] fin_d_q;
	logic [NMOD-1:0] fin_act;
	logic [NMOD-1:0] fin_prev_act;
	logic [NMOD-1:0] in_event;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fin_m_q <= '0;
			fin_s_q <= '0;
			fin_d_q <= '0;
		end else begin
			fin_m_q <= fault_in;
			fin_s_q <= fin_m_q;
			fin_d_q <= fin_s_q;
		end
	end
	assign fin_act      = ~(fin_s_q ^ fault_active_high);
	assign fin_prev_act = ~(fin_d_q ^ fault_active_high);
	// Edge and level-onset both reduce to the first active sample
	assign in_event = fin_act & ~fin_prev_act
		& (fault_level_mode | ~fault_level_mode);

	// ============================================================
	// Per-module compares, counter and waveforms
	pscr_cmp_t sa_buf_q [NMOD];
	pscr_cmp_t ra_buf_q [NMOD];
	pscr_cmp_t sb_buf_q [NMOD];
	pscr_cmp_t rb_buf_q [NMOD];
	pscr_cmp_t sa_q     [NMOD];
	pscr_cmp_t ra_q     [NMOD];
	pscr_cmp_t sb_q     [NMOD];
	pscr_cmp_t rb_q     [NMOD];
	pscr_cmp_t cnt_q    [NMOD];
	pscr_dir_e dir_q    [NMOD];
	logic [NMOD-1:0] end_cyc;
	logic [NMOD-1:0] m_sa;
	logic [NMOD-1:0] m_ra;
	logic [NMOD-1:0] m_sb;
	logic [NMOD-1:0] m_rb;
	logic [NMOD-1:0] flt_a;
	logic [NMOD-1:0] trig_d;
	logic            cycle_end;
	assign cycle_end = end_cyc[0];

	for (genvar n = 0; n < NMOD; n++) begin : g_mod
		logic sel;
		assign sel     = wr_en && in_mod && (mod_sel == 2'(n));
		assign m_sa[n] = mod_tick && (cnt_q[n] == sa_q[n]);
		assign m_ra[n] = mod_tick && (cnt_q[n] == ra_q[n]);
		assign m_sb[n] = mod_tick && (cnt_q[n] == sb_q[n]);
		assign m_rb[n] = mod_tick && (cnt_q[n] == rb_q[n]);
		assign flt_a[n] = in_event[n];
		assign end_cyc[n] = centred
			? (mod_tick && dir_q[n] == PSCR_DIR_DOWN && cnt_q[n] == 12'h000)
			: m_rb[n];

		// Low-byte write commits temp and low byte together
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				sa_buf_q[n] <= `PSCR_RST_CMP;
				ra_buf_q[n] <= `PSCR_RST_CMP;
				sb_buf_q[n] <= `PSCR_RST_CMP;
				rb_buf_q[n] <= `PSCR_RST_CMP;
			end else if (sel) begin
				if (mhit(mod_off, `PSCR_OFF_SA_L))
					sa_buf_q[n] <= {temp_q[3:0], wbyte};
				if (mhit(mod_off, `PSCR_OFF_RA_L))
					ra_buf_q[n] <= {temp_q[3:0], wbyte};
				if (mhit(mod_off, `PSCR_OFF_SB_L))
					sb_buf_q[n] <= {temp_q[3:0], wbyte};
				if (mhit(mod_off, `PSCR_OFF_RB_L))
					rb_buf_q[n] <= {temp_q[3:0], wbyte};
			end
		end

		// Active copies move only unlocked and at cycle end, or while stopped
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				sa_q[n] <= `PSCR_RST_CMP;
				ra_q[n] <= `PSCR_RST_CMP;
				sb_q[n] <= `PSCR_RST_CMP;
				rb_q[n] <= `PSCR_RST_CMP;
			end else if (!lock && (cycle_end || !run)) begin
				sa_q[n] <= sa_buf_q[n];
				ra_q[n] <= ra_buf_q[n];
				sb_q[n] <= sb_buf_q[n];
				rb_q[n] <= rb_buf_q[n];
			end
		end

		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				cnt_q[n] <= 12'h000;
				dir_q[n] <= PSCR_DIR_UP;
			end else if (!run) begin
				cnt_q[n] <= 12'h000;
				dir_q[n] <= PSCR_DIR_UP;
			end else if (mod_tick) begin
				if (!centred) begin
					cnt_q[n] <= m_rb[n] ? 12'h000 : cnt_q[n] + 12'h001;
				end else if (dir_q[n] == PSCR_DIR_UP) begin
					if (cnt_q[n] == rb_q[n] || cnt_q[n] == `PSCR_CNT_TOP) begin
						dir_q[n] <= PSCR_DIR_DOWN;
						cnt_q[n] <= cnt_q[n] - 12'h001;
					end else begin
						cnt_q[n] <= cnt_q[n] + 12'h001;
					end
				end else if (cnt_q[n] == 12'h000) begin
					dir_q[n] <= PSCR_DIR_UP;
					cnt_q[n] <= 12'h001;
				end else begin
					cnt_q[n] <= cnt_q[n] - 12'h001;
				end
			end
		end

		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				waveform_out_a[n] <= 1'b0;
				waveform_out_b[n] <= 1'b0;
			end else if (!run) begin
				waveform_out_a[n] <= 1'b0;
				waveform_out_b[n] <= 1'b0;
			end else begin
				if (m_ra[n] || flt_a[n])
					waveform_out_a[n] <= 1'b0;
				else if (m_sa[n])
					waveform_out_a[n] <= 1'b1;
				if (m_rb[n] || flt_a[n])
					waveform_out_b[n] <= 1'b0;
				else if (m_sb[n])
					waveform_out_b[n] <= 1'b1;
			end
		end

		// ADC trigger source per module
		always_comb begin
			trig_d[n] = 1'b0;
			if (centred) begin
				case (pscr_trig_e'(sync_q[2*n +: 2]))
					PSCR_TRIG_A_LEAD:  trig_d[n] = m_ra[n] && dir_q[n] == PSCR_DIR_DOWN;
					PSCR_TRIG_A_TRAIL: trig_d[n] = m_ra[n] && dir_q[n] == PSCR_DIR_UP;
					default:           trig_d[n] = 1'b0;
				endcase
			end else begin
				case (pscr_trig_e'(sync_q[2*n +: 2]))
					PSCR_TRIG_A_LEAD:  trig_d[n] = m_sa[n];
					PSCR_TRIG_A_TRAIL: trig_d[n] = m_ra[n] || flt_a[n];
					PSCR_TRIG_B_LEAD:  trig_d[n] = m_sb[n];
					default:           trig_d[n] = m_rb[n] || flt_a[n];
				endcase
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			adc_trigger <= '0;
		end else begin
			adc_trigger <= trig_d;
		end
	end

	// ============================================================
	// Pin enables, buffered behind the lock
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			poe_buf_q <= `PSCR_RST_BYTE;
		end else if (wr_en && hit(paddr, `PSCR_OFF_POE)) begin
			poe_buf_q <= wbyte & `PSCR_POE_MASK;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			poe_act_q <= `PSCR_RST_BYTE;
		end else if (!lock && (cycle_end || !run)) begin
			poe_act_q <= poe_buf_q;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pin_out <= '0;
		end else begin
			for (int i = 0; i < NMOD; i++) begin
				pin_out[2*i]   <= poe_act_q[2*i]   ? waveform_out_a[i] : port_out[2*i];
				pin_out[2*i+1] <= poe_act_q[2*i+1] ? waveform_out_b[i] : port_out[2*i+1];
			end
		end
	end

	// ============================================================
	// Flags: bit0 end of cycle, bits 3:1 input events, bits 6:4 sync errors
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	assign flag_set = {1'b0, sync_error, in_event, cycle_end};
	assign flag_clr = (wr_en && hit(paddr, `PSCR_OFF_IFLG)) ? (wbyte & 8'h7f) : 8'h00;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			iflg_q <= `PSCR_RST_BYTE;
		end else begin
			iflg_q <= (iflg_q & ~flag_clr) | flag_set;
		end
	end

	// Each module raises its own request line
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			module_irq              <= '0;
			fault_vector_req        <= 1'b0;
			end_of_cycle_vector_req <= 1'b0;
		end else begin
			for (int i = 0; i < NMOD; i++)
				module_irq[i] <= (iflg_q[i+1] & imsk_q[i+1]) | iflg_q[i+4];
			fault_vector_req        <= |(iflg_q[NMOD:1] & imsk_q[NMOD:1]);
			end_of_cycle_vector_req <= iflg_q[0] & imsk_q[0];
		end
	end

	// ============================================================
	// Read mux
	localparam logic [15:0] VEC_END_ADR   = `PSCR_VEC_END_ADR;
	localparam logic [15:0] VEC_FAULT_ADR = `PSCR_VEC_FAULT_ADR;
	logic [7:0] mod_rd;
	always_comb begin
		mod_rd = 8'h00;
		case (12'(mod_off))
			`PSCR_OFF_SA_L:   mod_rd = sa_buf_q[mod_sel][7:0];
			`PSCR_OFF_SA_H:   mod_rd = {4'h0, sa_buf_q[mod_sel][11:8]};
			`PSCR_OFF_RA_L:   mod_rd = ra_buf_q[mod_sel][7:0];
			`PSCR_OFF_RA_H:   mod_rd = {4'h0, ra_buf_q[mod_sel][11:8]};
			`PSCR_OFF_SB_L:   mod_rd = sb_buf_q[mod_sel][7:0];
			`PSCR_OFF_SB_H:   mod_rd = {4'h0, sb_buf_q[mod_sel][11:8]};
			`PSCR_OFF_RB_L:   mod_rd = rb_buf_q[mod_sel][7:0];
			`PSCR_OFF_RB_H:   mod_rd = {4'h0, rb_buf_q[mod_sel][11:8]};
			`PSCR_OFF_CNT:    mod_rd = cnt_q[mod_sel][7:0];
			default:          mod_rd = 8'h00;
		endcase
	end

	always_comb begin
		prdata  = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (in_mod && mod_sel < 2'(NMOD)) begin
			prdata = {24'h000000, mod_rd};
		end else begin
			case (paddr)
				`PSCR_OFF_POE:  prdata = {24'h000000, poe_buf_q};
				`PSCR_OFF_SYNC: prdata = {24'h000000, sync_q};
				`PSCR_OFF_CNF:  prdata = {24'h000000, cnf_q};
				`PSCR_OFF_CTL:  prdata = {24'h000000, ctl_q};
				`PSCR_OFF_IMSK: prdata = {24'h000000, imsk_q};
				`PSCR_OFF_IFLG: prdata = {24'h000000, iflg_q};
				`PSCR_OFF_STAT: prdata = {24'h000000, 5'h00, adc_trigger};
				`PSCR_OFF_VEC:  prdata = {VEC_END_ADR[7:0], `PSCR_VEC_END_NUM,
					VEC_FAULT_ADR[7:0], `PSCR_VEC_FAULT_NUM};
				default: begin
					prdata = 32'h0000_0000;
					rd_hit = 1'b0;
				end
			endcase
		end
	end
	assign pslverr = psel & penable & ~rd_hit;
endmodule

// ==== verilog/pscr_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the PWM stage control slice
`ifndef PSCR_REGS_SVH
`define PSCR_REGS_SVH

// ============================================================
// Register byte offsets on APB (module n compares at base + 0x40*n)
`define PSCR_OFF_POE        12'h000
`define PSCR_OFF_SYNC       12'h004
`define PSCR_OFF_CNF        12'h008
`define PSCR_OFF_CTL        12'h00c
`define PSCR_OFF_IMSK       12'h010
`define PSCR_OFF_IFLG       12'h014
`define PSCR_OFF_STAT       12'h018
`define PSCR_OFF_VEC        12'h01c
`define PSCR_OFF_MOD_BASE   12'h040
`define PSCR_MOD_STRIDE     12'h040
`define PSCR_OFF_SA_L       12'h000
`define PSCR_OFF_SA_H       12'h004
`define PSCR_OFF_RA_L       12'h008
`define PSCR_OFF_RA_H       12'h00c
`define PSCR_OFF_SB_L       12'h010
`define PSCR_OFF_SB_H       12'h014
`define PSCR_OFF_RB_L       12'h018
`define PSCR_OFF_RB_H       12'h01c
`define PSCR_OFF_CNT        12'h020

// ============================================================
// Field positions
`define PSCR_CNF_LOCK       5
`define PSCR_CNF_MODE       4
`define PSCR_CTL_PRE_HI     7
`define PSCR_CTL_PRE_LO     6
`define PSCR_CTL_CLKSEL     5
`define PSCR_CTL_RUN        0

// ============================================================
// Write masks and reset values
`define PSCR_POE_MASK       8'h3f
`define PSCR_SYNC_MASK      8'h3f
`define PSCR_CNF_MASK       8'h30
`define PSCR_CTL_MASK       8'he1
`define PSCR_HI_MASK        8'h0f
`define PSCR_RST_BYTE       8'h00
`define PSCR_RST_CMP        12'h000
`define PSCR_CNT_TOP        12'hfff

// ============================================================
// Interrupt vector figures
`define PSCR_VEC_FAULT_NUM  8'h05
`define PSCR_VEC_FAULT_ADR  16'h0004
`define PSCR_VEC_END_NUM    8'h06
`define PSCR_VEC_END_ADR    16'h0005

// ============================================================
// Prescaler divide counts
`define PSCR_DIV_1          9'h001
`define PSCR_DIV_4          9'h004
`define PSCR_DIV_32         9'h020
`define PSCR_DIV_256        9'h100

`endif

// ==== verilog/pscr_pkg.sv ====
// Types shared by the PWM stage control slice
package pscr_pkg;
	typedef logic [11:0] pscr_cmp_t;
	typedef enum logic [1:0] {
		PSCR_TRIG_A_LEAD,
		PSCR_TRIG_A_TRAIL,
		PSCR_TRIG_B_LEAD,
		PSCR_TRIG_B_TRAIL
	} pscr_trig_e;
	typedef enum logic {
		PSCR_DIR_UP,
		PSCR_DIR_DOWN
	} pscr_dir_e;
endpackage

// ==== verification/pscr_switch_model.sv ====
// Behavioural model of the external power switches and their trip sensing
`timescale 1ns/1ps
module pscr_switch_model (
	input  wire logic       mclk,
	input  wire logic [2:0] trip,
	input  wire logic [2:0] act_high,
	output logic      [2:0] fault_in
);
	// ============================================================
	// Trip reporting
	// A trip shows at the configured active level; an idle switch sits inactive
	always_ff @(posedge mclk) begin
		fault_in <= trip ~^ act_high;
	end
endmodule

// ==== verification/pscr_stage_chk.sv ====
// Port-level assertions for the PWM stage control slice
`timescale 1ns/1ps
module pscr_stage_chk #(
	parameter int NMOD = 3
) (
	input wire logic              mclk,
	input wire logic              reset,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [2*NMOD-1:0] pin_out,
	input wire logic [NMOD-1:0]   adc_trigger,
	input wire logic [NMOD-1:0]   module_irq,
	input wire logic              fault_vector_req,
	input wire logic              end_of_cycle_vector_req
);
	// ============================================================
	// Helpers
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	wire rd = psel && penable && !pwrite;
	// Requests may only drop through a software write to the mask or flag word
	wire fw = psel && penable && pwrite && (paddr == 12'h010 || paddr == 12'h014);

	// ============================================================
	// Properties
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access phase stalled");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_err_rd; rd && pslverr |-> prdata == 32'h0; endproperty
	a_err_rd: assert property (p_err_rd) else $error("refused read not zero");
	property p_vec; rd && paddr == 12'h01c |-> prdata == 32'h05060405; endproperty
	a_vec: assert property (p_vec) else $error("vector word wrong");
	property p_poe; rd && paddr inside {12'h000, 12'h004} |-> prdata[31:6] == 0; endproperty
	a_poe: assert property (p_poe) else $error("unused enable bits set");
	property p_cnf; rd && paddr == 12'h008 |-> (prdata & ~32'h30) == 0; endproperty
	a_cnf: assert property (p_cnf) else $error("unused config bits set");
	property p_hi;
		rd && paddr >= 12'h040 && paddr < 12'h100 && paddr[2] && !paddr[5]
			|-> prdata[31:4] == 0;
	endproperty
	a_hi: assert property (p_hi) else $error("high byte too wide");
	property p_end; $fell(end_of_cycle_vector_req) |-> $past(fw, 2); endproperty
	a_end: assert property (p_end) else $error("end request dropped alone");
	property p_flt; $fell(fault_vector_req) |-> $past(fw, 2); endproperty
	a_flt: assert property (p_flt) else $error("fault request dropped alone");
	property p_pulse; adc_trigger != 0 |=> (adc_trigger & $past(adc_trigger)) == 0; endproperty
	a_pulse: assert property (p_pulse) else $error("trigger longer than a cycle");
	property p_rst; $fell(reset) |-> pin_out == 0 && module_irq == 0 && !fault_vector_req;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs live after reset");
	c_flt: cover property ($rose(fault_vector_req));
	c_end: cover property ($rose(end_of_cycle_vector_req));
	c_trig: cover property (adc_trigger[0]);
	c_err: cover property (pslverr);
endmodule

bind pscr_stage pscr_stage_chk #(.NMOD(NMOD)) u_chk (
	.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pin_out(pin_out), .adc_trigger(adc_trigger), .module_irq(module_irq),
	.fault_vector_req(fault_vector_req), .end_of_cycle_vector_req(end_of_cycle_vector_req)
);

// ==== verification/test_pscr_stage.sv ====
// Self-checking bench for the PWM stage control slice
`timescale 1ns/1ps
module test_pscr_stage;
	logic        mclk = 0, reset = 1, pll_clk_en = 0, psel = 0, penable = 0, pwrite = 0;
	logic        pready, pslverr, er, fvr, evr;
	logic [2:0]  trip = 0, lvl = 0, act = 0, sync_error = 0, fault_in, wa, wb, irq, trg;
	logic [5:0]  port_out = 0, pin_out;
	logic [11:0] paddr = 0, v;
	logic [31:0] pwdata = 0, prdata, rv, eq[$], mq[$];
	int          n_errors = 0, compares = 0, seed = 4869, cyc = 0, n;
	int          dv[4] = '{1, 4, 32, 256};

	pscr_stage dut (
		.mclk(mclk), .reset(reset), .pll_clk_en(pll_clk_en), .fault_in(fault_in),
		.fault_level_mode(lvl), .fault_active_high(act), .sync_error(sync_error),
		.port_out(port_out), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_out(pin_out), .waveform_out_a(wa), .waveform_out_b(wb),
		.adc_trigger(trg), .module_irq(irq), .fault_vector_req(fvr),
		.end_of_cycle_vector_req(evr)
	);
	pscr_switch_model sw (.mclk(mclk), .trip(trip), .act_high(act), .fault_in(fault_in));

	// ============================================================
	// Clock, PLL tick enables and hang guard
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) pll_clk_en <= ~pll_clk_en;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			finish_test();
		end
	end

	// ============================================================
	// Helpers
	task automatic check(input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic finish_test;
		if (n_errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	function automatic logic [11:0] ca(input int m, r);
		return 12'(64 * m + 64 + 8 * r);
	endfunction
	// An idle edge before each setup keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
		eq.push_back(e);
		mq.push_back(m);
		apb(0, a, 0);
	endtask
	task automatic wcmp(input int m, r, input logic [11:0] x);
		apb(1, ca(m, r) + 12'h4, 32'(x[11:8]));
		apb(1, ca(m, r), 32'(x[7:0]));
	endtask
	// Read results are judged against the oldest note
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && eq.size() > 0) begin
			check(prdata & mq[0], eq[0] & mq[0]);
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
	end

	// ============================================================
	// Scenarios
	initial begin
		act = 3'($random(seed));
		repeat (8) @(posedge mclk);
		reset <= 0;
		for (int a = 0; a < 24; a += 4) rd(12'(a), 0, '1);
		for (int a = 64; a < 256; a += 4) if (a % 64 < 32) rd(12'(a), 0, '1);
		rd(12'h01c, 32'h05060405, '1);
		rd(12'h3f0, 0, '1);
		check(32'(er), 1);
		apb(1, 12'h000, '1);
		apb(1, 12'h004, '1);
		apb(1, 12'h008, '1);
		rd(12'h000, 32'h3f, '1);
		rd(12'h004, 32'h3f, '1);
		rd(12'h008, 32'h30, '1);
		apb(1, 12'h008, 0);
		for (int m = 0; m < 3; m++) for (int r = 0; r < 4; r++) begin
			v = 12'($random(seed));
			wcmp(m, r, v);
			rd(ca(m, r) + 12'h4, 32'(v[11:8]), '1);
			rd(ca(m, r), 32'(v[7:0]), '1);
		end
		apb(1, ca(0, 0) + 12'h4, 32'hfa);
		apb(1, ca(2, 3), 32'h5c);
		rd(ca(2, 3) + 12'h4, 32'h0a, '1);
		apb(1, 12'h000, 0);
		port_out <= 6'($random(seed)) | 6'h21;
		repeat (3) @(posedge mclk);
		check(32'(pin_out), 32'(port_out));
		apb(1, 12'h008, 32'h20);
		apb(1, 12'h000, 32'h3f);
		repeat (3) @(posedge mclk);
		check(32'(pin_out), 32'(port_out));
		apb(1, 12'h008, 0);
		repeat (3) @(posedge mclk);
		check(32'({pin_out, wa, wb}), 0);
		for (int m = 0; m < 3; m++) begin
			lvl <= 3'($random(seed));
			trip[m] <= 1;
			repeat (5) @(posedge mclk);
			rd(12'h014, 32'(2 << m), '1);
			check(32'(fvr), 0);
			apb(1, 12'h010, 32'(2 << m));
			repeat (2) @(posedge mclk);
			check(32'({fvr, irq}), 32'(8 | (1 << m)));
			apb(1, 12'h014, 32'(2 << m));
			rd(12'h014, 0, '1);
			trip[m] <= 0;
			apb(1, 12'h010, 0);
		end
		sync_error <= 3'b100;
		@(posedge mclk);
		sync_error <= 0;
		repeat (2) @(posedge mclk);
		rd(12'h014, 32'h40, '1);
		check(32'(irq), 32'h4);
		apb(1, 12'h014, 32'h40);
		for (int r = 0; r < 4; r++) wcmp(0, r, 12'(32 * r + 32));
		for (int i = 0; i < 8; i++) begin
			apb(1, 12'h008, 32'(i / 4 * 16));
			apb(1, 12'h004, 32'(i % 4));
			apb(1, 12'h00c, 1);
			n = 0;
			repeat (700) begin
				@(posedge mclk);
				n += int'(trg[0]);
			end
			check(32'(n > 0), 32'(i < 6));
			apb(1, 12'h00c, 0);
		end
		rd(12'h014, 1, 1);
		apb(1, 12'h010, 1);
		repeat (2) @(posedge mclk);
		check(32'(evr), 1);
		apb(1, 12'h014, 1);
		repeat (2) @(posedge mclk);
		check(32'(evr), 0);
		wcmp(0, 3, 12'hfff);
		for (int i = 0; i < 6; i++) begin
			n = dv[i % 4] * (i / 4 + 1);
			apb(1, 12'h00c, 32'({2'(i % 4), i > 3, 5'h01}));
			rd(12'h060, 0, 0);
			v = 12'(rv);
			repeat (32 * n - 3) @(posedge mclk);
			rd(12'h060, 0, 0);
			check(32'(8'(rv[7:0] - v[7:0]) inside {8'd31, 8'd32, 8'd33}), 1);
		end
		finish_test();
	end
endmodule
